/* File: logic/lsm_defines.svh */
// lsm_defines.svh: lane-map mode codes, widths and reset values of the lane sample mapper
// assumes inclusion by lsm_pkg and by the design modules; guarded against double inclusion
`ifndef LSM_DEFINES_SVH
`define LSM_DEFINES_SVH

// ****************************************
// widths and positions
// ****************************************
`define LSM_MODE_W   7
`define LSM_LANES    8
`define LSM_FLAG_BIT 0
`define LSM_LANE_RST 16'h0000

// ****************************************
// lane-map mode codes
// ****************************************
`define LSM_M16 7'h10
`define LSM_M19 7'h13
`define LSM_M42 7'h2A
`define LSM_M20 7'h14
`define LSM_M43 7'h2B
`define LSM_M21 7'h15
`define LSM_M36 7'h24
`define LSM_M22 7'h16
`define LSM_M46 7'h2E
`define LSM_M23 7'h17
`define LSM_M38 7'h26
`define LSM_M61 7'h3D
`define LSM_M64 7'h40
`define LSM_M69 7'h45
`define LSM_M71 7'h47
`define LSM_M24 7'h18
`define LSM_M48 7'h30
`define LSM_M62 7'h3E
`define LSM_M65 7'h41
`define LSM_M70 7'h46
`define LSM_M25 7'h19
`define LSM_M52 7'h34
`define LSM_M26 7'h1A
`define LSM_M54 7'h36
`define LSM_M63 7'h3F

`endif

/* File: logic/lsm_mapper.sv */
// lsm_mapper: lane sample mapper, samples and flags onto 2x8 lane words
// assumes sample inputs synchronous to CLK_I and a link encoder downstream
`timescale 1ns/1ps
`include "lsm_defines.svh"
module lsm_mapper
    import lsm_pkg::*;
(
    input  logic        CLK_I,
    input  logic        RST_B_I,
    input  logic        LINK_EN_I,
    input  lsm_mode_t   LANE_MAP_MODE_I,
    input  logic        SAMPLE_VALID_I,
    input  lsm_single_t SINGLE_I,
    input  lsm_dual_t   DUAL_I,
    input  lsm_bypass_t BYPASS_I,
    output lsm_lanes_t  LANES_O,
    output logic        LANE_VALID_O,
    output logic        LINK_UP_O,
    output logic        MODE_ERR_O
);

    // ****************************************
    // state
    // ****************************************
    typedef enum logic {LSM_IDLE, LSM_RUN} lsm_state_t;

    typedef struct packed {
        lsm_state_t state;
        lsm_class_t cls;
        lsm_lanes_t lanes;
        logic       valid;
        logic       link_up;
        logic       mode_err;
    } lsm_regs_t;

    lsm_regs_t r;
    lsm_regs_t next_r;

    lsm_s12_t [1:0][3:0]  set_a;
    lsm_s12_t [1:0][3:0]  set_b;
    lsm_word_t [1:0][2:0] pk_a;
    lsm_word_t [1:0][2:0] pk_b;
    lsm_lanes_t           byp_lanes;
    lsm_lanes_t           cplx_lanes;
    lsm_lanes_t           mapped;
    lsm_class_t           req_cls;

    // ****************************************
    // 15-bit placement
    // ****************************************
    lsm_place15 u_place15 (
        .cls_i    (r.cls),
        .single_i (SINGLE_I),
        .dual_i   (DUAL_I),
        .lanes_o  (cplx_lanes)
    );

    // ****************************************
    // 12-bit bypass packing
    // ****************************************
    always_comb begin
        for (int j = 0; j < 2; j++) begin
            for (int m = 0; m < 4; m++) begin
                if (r.cls == LSM_C_BYP2) begin
                    // channel a samples 0-7, channel b samples 8-15
                    set_a[j][m] = BYPASS_I[4*j+m];
                    set_b[j][m] = BYPASS_I[8+4*j+m];
                end else begin
                    // even samples group a, odd samples group b
                    set_a[j][m] = BYPASS_I[8*j+2*m];
                    set_b[j][m] = BYPASS_I[8*j+2*m+1];
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pack
            lsm_pack12 u_pack_a (
                .s_i (set_a[g]),
                .w_o (pk_a[g])
            );
            lsm_pack12 u_pack_b (
                .s_i (set_b[g]),
                .w_o (pk_b[g])
            );
        end
    endgenerate

    always_comb begin
        byp_lanes = '0;
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 3; i++) begin
                // three-lane sets, lanes 6-7 idle
                byp_lanes.lane_a[3*j+i] = pk_a[j][i];
                byp_lanes.lane_b[3*j+i] = pk_b[j][i];
            end
        end
    end

    always_comb begin
        case (r.cls)
            LSM_C_BYP1, LSM_C_BYP2: mapped = byp_lanes;
            default:                mapped = cplx_lanes;
        endcase
    end

    // ****************************************
    // control
    // ****************************************
    // mode aliases resolve to one placement class
    assign req_cls = lsm_decode(LANE_MAP_MODE_I);

    always_comb begin
        next_r       = r;
        next_r.valid = 1'b0;
        case (r.state)
            LSM_IDLE: begin
                next_r.lanes = '0;
                if (LINK_EN_I) begin
                    // mode captured at link start only
                    next_r.state    = LSM_RUN;
                    next_r.link_up  = 1'b1;
                    next_r.cls      = req_cls;
                    next_r.mode_err = (req_cls == LSM_C_NONE);
                end
            end
            LSM_RUN: begin
                if (!LINK_EN_I) begin
                    next_r.state   = LSM_IDLE;
                    next_r.link_up = 1'b0;
                    next_r.lanes   = '0;
                end else if (SAMPLE_VALID_I && r.cls != LSM_C_NONE) begin
                    next_r.lanes = mapped;
                    next_r.valid = 1'b1;
                end
            end
            default: begin
                next_r = '0;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign LANES_O      = r.lanes;
    assign LANE_VALID_O = r.valid;
    assign LINK_UP_O    = r.link_up;
    assign MODE_ERR_O   = r.mode_err;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    property p_d8x16;
        LANE_VALID_O && r.cls == LSM_C_D8X16 |->
            LANES_O.lane_a[3] == {$past(DUAL_I.chan_a_inphase[3]), $past(DUAL_I.chan_a_inphase_overrange[3])}
            && LANES_O.lane_b[5] == {$past(DUAL_I.chan_b_quad[1]), $past(DUAL_I.chan_b_quad_overrange[1])};
    endproperty
    a_d8x16: assert property (p_d8x16) else $error("dual 16-lane placement wrong");

    property p_byp1;
        LANE_VALID_O && r.cls == LSM_C_BYP1 |->
            LANES_O.lane_a[1] == {$past(BYPASS_I[2][7:0]), $past(BYPASS_I[4][11:4])}
            && LANES_O.lane_b[5] == {$past(BYPASS_I[13][3:0]), $past(BYPASS_I[15])};
    endproperty
    a_byp1: assert property (p_byp1) else $error("single bypass packing wrong");

    property p_byp2;
        LANE_VALID_O && r.cls == LSM_C_BYP2 |->
            LANES_O.lane_a[0] == {$past(BYPASS_I[0]), $past(BYPASS_I[1][11:8])}
            && LANES_O.lane_b[2] == {$past(BYPASS_I[10][3:0]), $past(BYPASS_I[11])};
    endproperty
    a_byp2: assert property (p_byp2) else $error("dual bypass packing wrong");

    property p_alias;
        $rose(LINK_UP_O) |->
            ($past(LANE_MAP_MODE_I) != `LSM_M42 || r.cls == LSM_C_BYP1)
            && ($past(LANE_MAP_MODE_I) != `LSM_M36 || r.cls == LSM_C_SG2)
            && ($past(LANE_MAP_MODE_I) != `LSM_M46 || r.cls == LSM_C_SG4)
            && ($past(LANE_MAP_MODE_I) != `LSM_M71 || r.cls == LSM_C_SG1)
            && ($past(LANE_MAP_MODE_I) != `LSM_M70 || r.cls == LSM_C_SG2)
            && ($past(LANE_MAP_MODE_I) != `LSM_M52 || r.cls == LSM_C_SG8H)
            && ($past(LANE_MAP_MODE_I) != `LSM_M38 || r.cls == LSM_C_SG1)
            && ($past(LANE_MAP_MODE_I) != `LSM_M61 || r.cls == LSM_C_SG1)
            && ($past(LANE_MAP_MODE_I) != `LSM_M64 || r.cls == LSM_C_SG1)
            && ($past(LANE_MAP_MODE_I) != `LSM_M69 || r.cls == LSM_C_SG1)
            && ($past(LANE_MAP_MODE_I) != `LSM_M48 || r.cls == LSM_C_SG2)
            && ($past(LANE_MAP_MODE_I) != `LSM_M62 || r.cls == LSM_C_SG2)
            && ($past(LANE_MAP_MODE_I) != `LSM_M65 || r.cls == LSM_C_SG2)
            && ($past(LANE_MAP_MODE_I) != `LSM_M54 || r.cls == LSM_C_SG4)
            && ($past(LANE_MAP_MODE_I) != `LSM_M63 || r.cls == LSM_C_SG4);
    endproperty
    a_alias: assert property (p_alias) else $error("mode alias class wrong");

    property p_sg2;
        LANE_VALID_O && r.cls == LSM_C_SG2 |->
            LANES_O.lane_b[1] == {$past(SINGLE_I.quad[1]), $past(SINGLE_I.quad_overrange[1])}
            && LANES_O.lane_a[2] == `LSM_LANE_RST;
    endproperty
    a_sg2: assert property (p_sg2) else $error("4-lane placement wrong");

    property p_sg4;
        LANE_VALID_O && r.cls == LSM_C_SG4 |->
            LANES_O.lane_a[3][15:1] == $past(SINGLE_I.inphase[3])
            && LANES_O.lane_a[3][`LSM_FLAG_BIT] == $past(SINGLE_I.inphase_overrange[3])
            && LANES_O.lane_a[4] == `LSM_LANE_RST;
    endproperty
    a_sg4: assert property (p_sg4) else $error("8-lane placement wrong");

    property p_sg1;
        LANE_VALID_O && r.cls == LSM_C_SG1 |->
            LANES_O.lane_b[0] == {$past(SINGLE_I.quad[0]), $past(SINGLE_I.quad_overrange[0])}
            && LANES_O.lane_a[1] == `LSM_LANE_RST;
    endproperty
    a_sg1: assert property (p_sg1) else $error("2-lane placement wrong");

    property p_sg8h;
        LANE_VALID_O && r.cls == LSM_C_SG8H |->
            LANES_O.lane_a[5] == {$past(SINGLE_I.inphase[5]), $past(SINGLE_I.inphase_overrange[2])}
            && LANES_O.lane_b[7] == {$past(SINGLE_I.quad[7]), $past(SINGLE_I.quad_overrange[3])};
    endproperty
    a_sg8h: assert property (p_sg8h) else $error("shared flag placement wrong");

    property p_static;
        LINK_UP_O ##1 LINK_UP_O |-> $stable(r.cls) && $stable(MODE_ERR_O);
    endproperty
    a_static: assert property (p_static) else $error("mode changed while link up");

    property p_valid;
        LINK_UP_O && LINK_EN_I && SAMPLE_VALID_I && !MODE_ERR_O |=> LANE_VALID_O;
    endproperty
    a_valid: assert property (p_valid) else $error("accepted sample not presented");

    property p_idle_quiet;
        !LINK_UP_O |-> !LANE_VALID_O && LANES_O == '0;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("lanes active while link down");

    property p_err_silent;
        MODE_ERR_O |-> !LANE_VALID_O;
    endproperty
    a_err_silent: assert property (p_err_silent) else $error("frame sent in unsupported mode");

    property p_stop;
        LINK_UP_O && !LINK_EN_I |=> !LINK_UP_O && LANES_O == '0;
    endproperty
    a_stop: assert property (p_stop) else $error("link stop not honoured");

    property p_start;
        !LINK_UP_O && LINK_EN_I |=> LINK_UP_O && !LANE_VALID_O;
    endproperty
    a_start: assert property (p_start) else $error("link start not honoured");

    property p_byp_spare;
        LANE_VALID_O && (r.cls == LSM_C_BYP1 || r.cls == LSM_C_BYP2) |->
            LANES_O.lane_a[7:6] == '0 && LANES_O.lane_b[7:6] == '0;
    endproperty
    a_byp_spare: assert property (p_byp_spare) else $error("bypass spare lanes not idle");

    property p_byp1_hi;
        LANE_VALID_O && r.cls == LSM_C_BYP1 |->
            LANES_O.lane_a[3] == {$past(BYPASS_I[8]), $past(BYPASS_I[10][11:8])}
            && LANES_O.lane_a[5] == {$past(BYPASS_I[12][3:0]), $past(BYPASS_I[14])};
    endproperty
    a_byp1_hi: assert property (p_byp1_hi) else $error("single bypass second set wrong");

    property p_byp2_hi;
        LANE_VALID_O && r.cls == LSM_C_BYP2 |->
            LANES_O.lane_a[3] == {$past(BYPASS_I[4]), $past(BYPASS_I[5][11:8])}
            && LANES_O.lane_b[4] == {$past(BYPASS_I[13][7:0]), $past(BYPASS_I[14][11:4])};
    endproperty
    a_byp2_hi: assert property (p_byp2_hi) else $error("dual bypass second set wrong");

    property p_d8x16_q;
        LANE_VALID_O && r.cls == LSM_C_D8X16 |->
            LANES_O.lane_a[4] == {$past(DUAL_I.chan_a_quad[0]), $past(DUAL_I.chan_a_quad_overrange[0])}
            && LANES_O.lane_b[2] == {$past(DUAL_I.chan_b_inphase[2]), $past(DUAL_I.chan_b_inphase_overrange[2])};
    endproperty
    a_d8x16_q: assert property (p_d8x16_q) else $error("dual 16-lane quad placement wrong");

    c_d8x16: cover property (LANE_VALID_O && r.cls == LSM_C_D8X16);
    c_byp1: cover property (LANE_VALID_O && r.cls == LSM_C_BYP1);
    c_byp2: cover property (LANE_VALID_O && r.cls == LSM_C_BYP2);
    c_sg8h: cover property (LANE_VALID_O && r.cls == LSM_C_SG8H);
    c_restart: cover property ($fell(LINK_UP_O) ##[1:20] $rose(LINK_UP_O));
endmodule

/* File: logic/lsm_pack12.sv */
// lsm_pack12: packs four 12-bit samples into three 16-bit lane words
// assumes a purely combinational use; caller registers the result
`timescale 1ns/1ps
module lsm_pack12
    import lsm_pkg::*;
(
    input  lsm_s12_t [3:0]  s_i,
    output lsm_word_t [2:0] w_o
);
    // second sample split 4/8, third split 8/4
    assign w_o[0] = {s_i[0], s_i[1][11:8]};
    assign w_o[1] = {s_i[1][7:0], s_i[2][11:4]};
    assign w_o[2] = {s_i[2][3:0], s_i[3]};
endmodule

/* File: logic/lsm_pkg.sv */
// lsm_pkg: types and helper functions of the lane sample mapper
// assumes lsm_defines.svh on the include path
package lsm_pkg;
`include "lsm_defines.svh"

    // ****************************************
    // sample and lane carriers
    // ****************************************
    typedef logic [11:0] lsm_s12_t;
    typedef logic [14:0] lsm_s15_t;
    typedef logic [15:0] lsm_word_t;
    typedef logic [`LSM_MODE_W-1:0] lsm_mode_t;
    typedef lsm_s12_t [15:0] lsm_bypass_t;

    typedef struct packed {
        lsm_s15_t [7:0] inphase;
        lsm_s15_t [7:0] quad;
        logic [3:0]     inphase_overrange;
        logic [3:0]     quad_overrange;
    } lsm_single_t;

    typedef struct packed {
        lsm_s15_t [3:0] chan_a_inphase;
        lsm_s15_t [3:0] chan_a_quad;
        lsm_s15_t [3:0] chan_b_inphase;
        lsm_s15_t [3:0] chan_b_quad;
        logic [3:0]     chan_a_inphase_overrange;
        logic [3:0]     chan_a_quad_overrange;
        logic [3:0]     chan_b_inphase_overrange;
        logic [3:0]     chan_b_quad_overrange;
    } lsm_dual_t;

    typedef struct packed {
        lsm_word_t [7:0] lane_a;
        lsm_word_t [7:0] lane_b;
    } lsm_lanes_t;

    // placement class of a lane-map mode
    typedef enum logic [3:0] {
        LSM_C_NONE, LSM_C_D8X16, LSM_C_SG1, LSM_C_SG2, LSM_C_SG4, LSM_C_SG8H, LSM_C_BYP1, LSM_C_BYP2
    } lsm_class_t;

    // ****************************************
    // functions
    // ****************************************
    function automatic lsm_class_t lsm_decode(input lsm_mode_t m);
        case (m)
            `LSM_M16:                                       return LSM_C_D8X16;
            `LSM_M19, `LSM_M42:                             return LSM_C_BYP1;
            `LSM_M20, `LSM_M43:                             return LSM_C_BYP2;
            `LSM_M23, `LSM_M38, `LSM_M61, `LSM_M64, `LSM_M69, `LSM_M71: return LSM_C_SG1;
            `LSM_M21, `LSM_M36, `LSM_M24, `LSM_M48, `LSM_M62, `LSM_M65, `LSM_M70: return LSM_C_SG2;
            `LSM_M22, `LSM_M46, `LSM_M26, `LSM_M54, `LSM_M63: return LSM_C_SG4;
            `LSM_M25, `LSM_M52:                             return LSM_C_SG8H;
            default:                                        return LSM_C_NONE;
        endcase
    endfunction

    // sample in the upper bits, flag in the lsb
    function automatic lsm_word_t lsm_word15(input lsm_s15_t s, input logic f);
        return {s, f};
    endfunction

    function automatic int lsm_group_lanes(input lsm_class_t c);
        case (c)
            LSM_C_SG1:  return 1;
            LSM_C_SG2:  return 2;
            LSM_C_SG4:  return 4;
            LSM_C_SG8H: return 8;
            default:    return 0;
        endcase
    endfunction
endpackage

/* File: logic/lsm_place15.sv */
// lsm_place15: places 15-bit complex samples and flags on the lanes
// assumes a purely combinational use; unused lanes read zero
`timescale 1ns/1ps
`include "lsm_defines.svh"
module lsm_place15
    import lsm_pkg::*;
(
    input  lsm_class_t  cls_i,
    input  lsm_single_t single_i,
    input  lsm_dual_t   dual_i,
    output lsm_lanes_t  lanes_o
);
    always_comb begin
        lanes_o = '0;
        for (int k = 0; k < `LSM_LANES; k++) begin
            if (cls_i == LSM_C_D8X16) begin
                if (k < 4) begin
                    // dual channel, in-phase lanes 0-3, quad lanes 4-7
                    lanes_o.lane_a[k]   = lsm_word15(dual_i.chan_a_inphase[k], dual_i.chan_a_inphase_overrange[k]);
                    lanes_o.lane_a[k+4] = lsm_word15(dual_i.chan_a_quad[k], dual_i.chan_a_quad_overrange[k]);
                    lanes_o.lane_b[k]   = lsm_word15(dual_i.chan_b_inphase[k], dual_i.chan_b_inphase_overrange[k]);
                    lanes_o.lane_b[k+4] = lsm_word15(dual_i.chan_b_quad[k], dual_i.chan_b_quad_overrange[k]);
                end
            end else if (k < lsm_group_lanes(cls_i)) begin
                if (cls_i == LSM_C_SG8H) begin
                    // two lanes share one flag index
                    lanes_o.lane_a[k] = lsm_word15(single_i.inphase[k], single_i.inphase_overrange[k/2]);
                    lanes_o.lane_b[k] = lsm_word15(single_i.quad[k], single_i.quad_overrange[k/2]);
                end else begin
                    // i on group a, q on group b
                    lanes_o.lane_a[k] = lsm_word15(single_i.inphase[k], single_i.inphase_overrange[k%4]);
                    lanes_o.lane_b[k] = lsm_word15(single_i.quad[k], single_i.quad_overrange[k%4]);
                end
            end
        end
    end
endmodule

/* File: testbench/lsm_rx_model.sv */
// lsm_rx_model: far-end lane receiver that captures each mapped frame
// assumes lanes and lane valid registered on the rising edge of clk_i
`timescale 1ns/1ps
module lsm_rx_model
    import lsm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire lsm_lanes_t lanes_i,
    input  wire logic       lane_valid_i,
    input  wire logic       link_up_i,
    output lsm_lanes_t      frame_o,
    output int              frames_o
);
    // ****************************************
    // frame capture
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_o  <= '0;
            frames_o <= 0;
        end else if (lane_valid_i && link_up_i) begin
            frame_o  <= lanes_i;
            frames_o <= frames_o + 1;
        end
    end
endmodule

/* File: testbench/testbench.sv */
// testbench: self-checking bench of the lane sample mapper
// assumes lsm_pkg compiled first and lsm_rx_model as far-end receiver
`timescale 1ns/1ps
module testbench
    import lsm_pkg::*;
;
    logic        clk, rst_b, link_en, svalid, lvalid, link_up, mode_err;
    lsm_mode_t   mode;
    lsm_single_t sg;
    lsm_dual_t   du;
    lsm_bypass_t by;
    lsm_lanes_t  lanes, frame;
    int          frames, fails, checks_done;
    lsm_mode_t   modes [25] = '{7'h10, 7'h13, 7'h2A, 7'h14, 7'h2B, 7'h15, 7'h24, 7'h16, 7'h2E, 7'h17, 7'h26, 7'h3D,
                                7'h40, 7'h45, 7'h47, 7'h18, 7'h30, 7'h3E, 7'h41, 7'h46, 7'h19, 7'h34, 7'h1A, 7'h36, 7'h3F};

    lsm_mapper dut_u (.CLK_I(clk), .RST_B_I(rst_b), .LINK_EN_I(link_en), .LANE_MAP_MODE_I(mode),
        .SAMPLE_VALID_I(svalid), .SINGLE_I(sg), .DUAL_I(du), .BYPASS_I(by), .LANES_O(lanes),
        .LANE_VALID_O(lvalid), .LINK_UP_O(link_up), .MODE_ERR_O(mode_err));
    lsm_rx_model rx_u (.clk_i(clk), .rst_b_i(rst_b), .lanes_i(lanes), .lane_valid_i(lvalid),
        .link_up_i(link_up), .frame_o(frame), .frames_o(frames));

    always #4 clk = ~clk;

    // ****************************************
    // expected lanes and checking
    // ****************************************
    function automatic lsm_lanes_t exp_lanes(input lsm_mode_t m);
        lsm_lanes_t e;
        lsm_s12_t   ga [8];
        lsm_s12_t   gb [8];
        logic [47:0] ca, cb;
        int n;
        e = '0;
        n = 0;
        case (m)
            7'h17, 7'h26, 7'h3D, 7'h40, 7'h45, 7'h47: n = 1;
            7'h15, 7'h24, 7'h18, 7'h30, 7'h3E, 7'h41, 7'h46: n = 2;
            7'h16, 7'h2E, 7'h1A, 7'h36, 7'h3F: n = 4;
            7'h19, 7'h34: n = 8;
            default: n = 0;
        endcase
        for (int k = 0; k < n; k++) begin
            e.lane_a[k] = {sg.inphase[k], sg.inphase_overrange[(n == 8) ? k / 2 : k]};
            e.lane_b[k] = {sg.quad[k], sg.quad_overrange[(n == 8) ? k / 2 : k]};
        end
        if (m == 7'h10) begin
            for (int k = 0; k < 4; k++) begin
                e.lane_a[k]     = {du.chan_a_inphase[k], du.chan_a_inphase_overrange[k]};
                e.lane_a[k + 4] = {du.chan_a_quad[k], du.chan_a_quad_overrange[k]};
                e.lane_b[k]     = {du.chan_b_inphase[k], du.chan_b_inphase_overrange[k]};
                e.lane_b[k + 4] = {du.chan_b_quad[k], du.chan_b_quad_overrange[k]};
            end
        end
        if (m == 7'h13 || m == 7'h2A || m == 7'h14 || m == 7'h2B) begin
            for (int k = 0; k < 8; k++) begin
                ga[k] = (m == 7'h13 || m == 7'h2A) ? by[2 * k] : by[k];
                gb[k] = (m == 7'h13 || m == 7'h2A) ? by[2 * k + 1] : by[8 + k];
            end
            for (int j = 0; j < 2; j++) begin
                ca = {ga[4 * j], ga[4 * j + 1], ga[4 * j + 2], ga[4 * j + 3]};
                cb = {gb[4 * j], gb[4 * j + 1], gb[4 * j + 2], gb[4 * j + 3]};
                {e.lane_a[3 * j], e.lane_a[3 * j + 1], e.lane_a[3 * j + 2]} = ca;
                {e.lane_b[3 * j], e.lane_b[3 * j + 1], e.lane_b[3 * j + 2]} = cb;
            end
        end
        return e;
    endfunction

    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // link and sample drivers
    // ****************************************
    task automatic start(input lsm_mode_t m, input logic err);
        @(posedge clk);
        link_en <= 1'b1;
        mode    <= m;
        @(posedge clk);
        @(negedge clk);
        check(256'(link_up), 256'(1'b1));
        check(256'(mode_err), 256'(err));
    endtask

    task automatic send(input lsm_mode_t m, input logic ok);
        @(posedge clk);
        svalid <= 1'b1;
        @(posedge clk);
        svalid <= 1'b0;
        @(negedge clk);
        check(256'(lvalid), 256'(ok));
        if (ok) check(lanes, exp_lanes(m));
    endtask

    task automatic stop();
        @(posedge clk);
        link_en <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        check(256'(link_up), 256'(1'b0));
        check(lanes, 256'(0));
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_idle();
        @(negedge clk);
        check(lanes, 256'(0));
        check(256'({lvalid, link_up, mode_err}), 256'(0));
        send(7'h17, 1'b0);
    endtask

    task automatic t_all_modes();
        foreach (modes[i]) begin
            start(modes[i], 1'b0);
            send(modes[i], 1'b1);
            stop();
            check(frame, exp_lanes(modes[i]));
        end
    endtask

    task automatic t_bad_mode();
        start(7'h0C, 1'b1);
        send(7'h0C, 1'b0);
        stop();
    endtask

    task automatic t_static_mode();
        start(7'h17, 1'b0);
        @(posedge clk);
        mode <= 7'h10;
        send(7'h17, 1'b1);
        stop();
    endtask

    task automatic t_back_to_back();
        lsm_lanes_t e1;
        start(7'h34, 1'b0);
        e1 = exp_lanes(7'h34);
        @(posedge clk);
        svalid <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 8; k++) sg.inphase[k] <= 15'h7F00 - 15'(k);
        sg.quad_overrange <= 4'h6;
        @(negedge clk);
        check(lanes, e1);
        @(posedge clk);
        svalid <= 1'b0;
        @(negedge clk);
        check(256'(lvalid), 256'(1'b1));
        check(lanes, exp_lanes(7'h34));
        stop();
    endtask

    task automatic t_mid_reset();
        start(7'h19, 1'b0);
        send(7'h19, 1'b1);
        @(posedge clk);
        rst_b   <= 1'b0;
        link_en <= 1'b0;
        @(negedge clk);
        check(lanes, 256'(0));
        check(256'({lvalid, link_up, mode_err}), 256'(0));
        @(posedge clk);
        rst_b <= 1'b1;
        start(7'h14, 1'b0);
        send(7'h14, 1'b1);
        stop();
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        link_en = 1'b0;
        svalid = 1'b0;
        mode = 7'h00;
        fails = 0;
        checks_done = 0;
        for (int k = 0; k < 8; k++) begin
            sg.inphase[k] = 15'h1230 + 15'(k);
            sg.quad[k]    = 15'h4560 + 15'(k);
        end
        for (int k = 0; k < 4; k++) begin
            du.chan_a_inphase[k] = 15'h1110 + 15'(k);
            du.chan_a_quad[k]    = 15'h2220 + 15'(k);
            du.chan_b_inphase[k] = 15'h3330 + 15'(k);
            du.chan_b_quad[k]    = 15'h4440 + 15'(k);
        end
        sg.inphase_overrange = 4'hA;
        sg.quad_overrange = 4'h5;
        du.chan_a_inphase_overrange = 4'h3;
        du.chan_a_quad_overrange = 4'hC;
        du.chan_b_inphase_overrange = 4'h6;
        du.chan_b_quad_overrange = 4'h9;
        for (int k = 0; k < 16; k++) by[k] = {4'(k), ~4'(k), 4'h5};
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_idle();
        t_all_modes();
        t_bad_mode();
        t_static_mode();
        t_back_to_back();
        check(256'(frames), 256'(28));
        t_mid_reset();
        give_verdict();
    end

    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule
